// >>> verilog/rra_reg_bank.v
// Summary of operation
// - single-byte access touches only the addressed register
// - incrementing burst steps through ascending registers from one start address
// - non-incrementing burst reads the same register again and again
// - bits follow access codes: read/write, read-only, write-only, unused
// - regulator, pin and signal-strength registers stay reachable during activity
// - start code file resets to its 64-bit default sequence
// - spreading code file resets to its 128-bit default sequence
// - preamble file resets to its 24-bit default value
// - registers read/write unless marked; write-only locations read back zero
`timescale 1ns/1ns
`include "rra_regs.vh"
module rra_reg_bank (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] pin_in,
  input wire [7:0] signal_strength_indicator_value,
  input wire [15:0] tx_crc,
  input wire [15:0] rx_crc,
  input wire [7:0] rx_byte,
  output wire rx_pop,
  output wire tx_push,
  output wire [7:0] tx_byte,
  output wire [511:0] reg_image,
  output wire [63:0] start_code,
  output wire [127:0] spread_code,
  output wire [23:0] lead_in
);
localparam K_NONE = 3'd0;
localparam K_RW = 3'd1;
localparam K_RO = 3'd2;
localparam K_WO = 3'd3;
localparam K_OWN = 3'd4;

function [7:0] wr_mask;
  input [5:0] idx;
  begin
    case (idx)
      `RRA_IDX_XTAL_CTRL: wr_mask = `RRA_MSK_XTAL_CTRL;
      `RRA_IDX_GPIO_CTRL: wr_mask = `RRA_MSK_GPIO_OUT;
      `RRA_IDX_XACT_CFG: wr_mask = `RRA_MSK_XACT_CFG;
      `RRA_IDX_TH32: wr_mask = `RRA_MSK_TH32;
      `RRA_IDX_TH64: wr_mask = `RRA_MSK_TH64;
      `RRA_IDX_TRIM_HI: wr_mask = `RRA_MSK_TRIM_HI;
      `RRA_IDX_OP_OVR: wr_mask = `RRA_MSK_OP_OVR;
      `RRA_IDX_RX_OVR: wr_mask = `RRA_MSK_RX_OVR;
      `RRA_IDX_XTAL_CFG: wr_mask = `RRA_MSK_XTAL_CFG;
      `RRA_IDX_CLK_FORCE: wr_mask = `RRA_MSK_CLK_BIT;
      `RRA_IDX_CLK_GATE: wr_mask = `RRA_MSK_CLK_BIT;
      `RRA_IDX_RX_ABORT: wr_mask = `RRA_MSK_RX_ABORT;
      `RRA_IDX_ANALOG: wr_mask = `RRA_MSK_ANALOG;
      `RRA_IDX_IO_CFG, `RRA_IDX_FRAMING_CFG, `RRA_IDX_EOP_CTRL, `RRA_IDX_SEED_LO,
      `RRA_IDX_SEED_HI, `RRA_IDX_TRIM_LO, `RRA_IDX_TX_OVR, `RRA_IDX_CAL_TIME,
      `RRA_IDX_CAL_OFFSET: wr_mask = `RRA_MSK_FULL;
      default: wr_mask = 8'h00;
    endcase
  end
endfunction

function [7:0] rst_val;
  input [5:0] idx;
  begin
    case (idx)
      `RRA_IDX_XTAL_CTRL: rst_val = `RRA_RST_XTAL_CTRL;
      `RRA_IDX_XACT_CFG: rst_val = `RRA_RST_XACT_CFG;
      `RRA_IDX_FRAMING_CFG: rst_val = `RRA_RST_FRAMING_CFG;
      `RRA_IDX_TH32: rst_val = `RRA_RST_TH32;
      `RRA_IDX_TH64: rst_val = `RRA_RST_TH64;
      `RRA_IDX_EOP_CTRL: rst_val = `RRA_RST_EOP_CTRL;
      `RRA_IDX_CAL_TIME: rst_val = `RRA_RST_CAL_TIME;
      default: rst_val = `RRA_RST_ZERO;
    endcase
  end
endfunction

function [2:0] acc_kind;
  input [5:0] idx;
  begin
    case (idx)
      `RRA_IDX_XTAL_CTRL, `RRA_IDX_IO_CFG, `RRA_IDX_XACT_CFG, `RRA_IDX_FRAMING_CFG,
      `RRA_IDX_TH32, `RRA_IDX_TH64, `RRA_IDX_EOP_CTRL, `RRA_IDX_SEED_LO,
      `RRA_IDX_SEED_HI, `RRA_IDX_TRIM_LO, `RRA_IDX_TRIM_HI, `RRA_IDX_RX_OVR,
      `RRA_IDX_TX_OVR, `RRA_IDX_START_CODE, `RRA_IDX_SPREAD_CODE,
      `RRA_IDX_LEAD_IN, `RRA_IDX_GPIO_CTRL: acc_kind = K_RW;
      `RRA_IDX_SIGNAL_STRENGTH_INDICATOR, `RRA_IDX_TXCRC_LO, `RRA_IDX_TXCRC_HI, `RRA_IDX_RXCRC_LO,
      `RRA_IDX_RXCRC_HI, `RRA_IDX_RX_BUF: acc_kind = K_RO;
      `RRA_IDX_OP_OVR, `RRA_IDX_TX_BUF, `RRA_IDX_XTAL_CFG, `RRA_IDX_CLK_FORCE,
      `RRA_IDX_CLK_GATE, `RRA_IDX_RX_ABORT, `RRA_IDX_CAL_TIME, `RRA_IDX_CAL_OFFSET,
      `RRA_IDX_ANALOG: acc_kind = K_WO;
      `RRA_IDX_BURST_ADDR, `RRA_IDX_BURST_DATA, `RRA_IDX_BURST_CTRL: acc_kind = K_OWN;
      default: acc_kind = K_NONE;
    endcase
  end
endfunction

reg [7:0] rf_ff [0:63];
reg [63:0] start_code_ff;
reg [127:0] spread_code_ff;
reg [23:0] lead_in_ff;
reg [2:0] start_ptr_ff;
reg [3:0] spread_ptr_ff;
reg [1:0] lead_ptr_ff;
reg [5:0] burst_ptr_ff;
reg burst_inc_ff;
reg [3:0] pin_meta_ff;
reg [3:0] pin_sync_ff;
reg [31:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg rx_pop_ff;
reg tx_push_ff;
reg [7:0] tx_byte_ff;
reg [5:0] addr_idx;
reg win_hit;
reg [5:0] eff_idx;
reg [2:0] kind;
reg [7:0] mask;
reg [7:0] rd_byte;
wire done;
integer i;

assign done = psel & penable & pready_ff;
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign rx_pop = rx_pop_ff;
assign tx_push = tx_push_ff;
assign tx_byte = tx_byte_ff;
assign start_code = start_code_ff;
assign spread_code = spread_code_ff;
assign lead_in = lead_in_ff;

genvar g;
generate
  for (g = 0; g < 64; g = g + 1)
  begin : img
    assign reg_image[g*8 +: 8] = rf_ff[g];
  end
endgenerate

// address decode, window redirect and read mux
always @*
begin
  addr_idx = paddr[7:2];
  win_hit = (addr_idx == `RRA_IDX_BURST_DATA);
  eff_idx = win_hit ? burst_ptr_ff : addr_idx;
  kind = acc_kind(eff_idx);
  if (win_hit && kind == K_OWN)
  begin
    kind = K_NONE;
  end
  mask = wr_mask(eff_idx);
  case (eff_idx)
    `RRA_IDX_GPIO_CTRL: rd_byte = {rf_ff[`RRA_IDX_GPIO_CTRL][7:4], pin_sync_ff};
    `RRA_IDX_SIGNAL_STRENGTH_INDICATOR: rd_byte = {signal_strength_indicator_value[7], 1'b0, signal_strength_indicator_value[5:0]};
    `RRA_IDX_TXCRC_LO: rd_byte = tx_crc[7:0];
    `RRA_IDX_TXCRC_HI: rd_byte = tx_crc[15:8];
    `RRA_IDX_RXCRC_LO: rd_byte = rx_crc[7:0];
    `RRA_IDX_RXCRC_HI: rd_byte = rx_crc[15:8];
    `RRA_IDX_RX_BUF: rd_byte = rx_byte;
    `RRA_IDX_START_CODE: rd_byte = start_code_ff[{start_ptr_ff, 3'b000} +: 8];
    `RRA_IDX_SPREAD_CODE: rd_byte = spread_code_ff[{spread_ptr_ff, 3'b000} +: 8];
    `RRA_IDX_LEAD_IN: rd_byte = lead_in_ff[{lead_ptr_ff, 3'b000} +: 8];
    `RRA_IDX_BURST_ADDR: rd_byte = {2'b00, burst_ptr_ff};
    `RRA_IDX_BURST_CTRL: rd_byte = {7'h00, burst_inc_ff};
    default: rd_byte = (kind == K_RW) ? (rf_ff[eff_idx] & mask) : 8'h00;
  endcase
  if (kind == K_NONE)
  begin
    rd_byte = 8'h00;
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    for (i = 0; i < 64; i = i + 1)
    begin
      rf_ff[i] <= rst_val(i[5:0]);
    end
    start_code_ff <= `RRA_RST_START_CODE;
    spread_code_ff <= `RRA_RST_SPREAD_CODE;
    lead_in_ff <= `RRA_RST_LEAD_IN;
    start_ptr_ff <= 3'h0;
    spread_ptr_ff <= 4'h0;
    lead_ptr_ff <= 2'h0;
    burst_ptr_ff <= 6'h00;
    burst_inc_ff <= 1'b0;
    pin_meta_ff <= 4'h0;
    pin_sync_ff <= 4'h0;
    prdata_ff <= 32'h0000_0000;
    pready_ff <= 1'b0;
    pslverr_ff <= 1'b0;
    rx_pop_ff <= 1'b0;
    tx_push_ff <= 1'b0;
    tx_byte_ff <= 8'h00;
  end
  else
  begin
    pin_meta_ff <= pin_in;
    pin_sync_ff <= pin_meta_ff;
    pready_ff <= psel & ~penable;
    if (psel & ~penable)
    begin
      prdata_ff <= {24'h00_0000, rd_byte};
      pslverr_ff <= (kind == K_NONE);
    end
    rx_pop_ff <= done & ~pwrite & (eff_idx == `RRA_IDX_RX_BUF);
    tx_push_ff <= done & pwrite & (eff_idx == `RRA_IDX_TX_BUF);
    if (done & pwrite & (eff_idx == `RRA_IDX_TX_BUF))
    begin
      tx_byte_ff <= pwdata[7:0];
    end
    // masked write of the addressed register only
    if (done & pwrite & (kind != K_NONE) & (mask != 8'h00))
    begin
      rf_ff[eff_idx] <= (rf_ff[eff_idx] & ~mask) | (pwdata[7:0] & mask);
    end
    if (done & pwrite & ~win_hit & (addr_idx == `RRA_IDX_BURST_ADDR))
    begin
      burst_ptr_ff <= pwdata[5:0];
    end
    else if (done & win_hit & burst_inc_ff & (kind != K_NONE))
    begin
      burst_ptr_ff <= burst_ptr_ff + 6'h01;
    end
    if (done & pwrite & ~win_hit & (addr_idx == `RRA_IDX_BURST_CTRL))
    begin
      burst_inc_ff <= pwdata[0];
    end
    // byte files step on each access, rewind on any other mapped access
    if (done & (kind != K_NONE))
    begin
      if (eff_idx == `RRA_IDX_START_CODE)
      begin
        if (pwrite)
        begin
          start_code_ff[{start_ptr_ff, 3'b000} +: 8] <= pwdata[7:0];
        end
        start_ptr_ff <= (start_ptr_ff == `RRA_LAST_START_CODE) ? 3'h0 : start_ptr_ff + 3'h1;
      end
      else
      begin
        start_ptr_ff <= 3'h0;
      end
      if (eff_idx == `RRA_IDX_SPREAD_CODE)
      begin
        if (pwrite)
        begin
          spread_code_ff[{spread_ptr_ff, 3'b000} +: 8] <= pwdata[7:0];
        end
        spread_ptr_ff <= (spread_ptr_ff == `RRA_LAST_SPREAD_CODE) ? 4'h0 : spread_ptr_ff + 4'h1;
      end
      else
      begin
        spread_ptr_ff <= 4'h0;
      end
      if (eff_idx == `RRA_IDX_LEAD_IN)
      begin
        if (pwrite)
        begin
          lead_in_ff[{lead_ptr_ff, 3'b000} +: 8] <= pwdata[7:0];
        end
        lead_ptr_ff <= (lead_ptr_ff == `RRA_LAST_LEAD_IN) ? 2'h0 : lead_ptr_ff + 2'h1;
      end
      else
      begin
        lead_ptr_ff <= 2'h0;
      end
    end
  end
end
endmodule // rra_reg_bank

// >>> verilog/rra_regs.vh
`ifndef RRA_REGS_VH
`define RRA_REGS_VH
// register indices; byte address is four times the index
`define RRA_IDX_XTAL_CTRL 6'h0c
`define RRA_IDX_IO_CFG 6'h0d
`define RRA_IDX_GPIO_CTRL 6'h0e
`define RRA_IDX_XACT_CFG 6'h0f
`define RRA_IDX_FRAMING_CFG 6'h10
`define RRA_IDX_TH32 6'h11
`define RRA_IDX_TH64 6'h12
`define RRA_IDX_SIGNAL_STRENGTH_INDICATOR 6'h13
`define RRA_IDX_EOP_CTRL 6'h14
`define RRA_IDX_SEED_LO 6'h15
`define RRA_IDX_SEED_HI 6'h16
`define RRA_IDX_TXCRC_LO 6'h17
`define RRA_IDX_TXCRC_HI 6'h18
`define RRA_IDX_RXCRC_LO 6'h19
`define RRA_IDX_RXCRC_HI 6'h1a
`define RRA_IDX_TRIM_LO 6'h1b
`define RRA_IDX_TRIM_HI 6'h1c
`define RRA_IDX_OP_OVR 6'h1d
`define RRA_IDX_RX_OVR 6'h1e
`define RRA_IDX_TX_OVR 6'h1f
`define RRA_IDX_TX_BUF 6'h20
`define RRA_IDX_RX_BUF 6'h21
`define RRA_IDX_START_CODE 6'h22
`define RRA_IDX_SPREAD_CODE 6'h23
`define RRA_IDX_LEAD_IN 6'h24
`define RRA_IDX_XTAL_CFG 6'h26
`define RRA_IDX_CLK_FORCE 6'h27
`define RRA_IDX_CLK_GATE 6'h28
`define RRA_IDX_RX_ABORT 6'h29
`define RRA_IDX_CAL_TIME 6'h32
`define RRA_IDX_CAL_OFFSET 6'h35
`define RRA_IDX_ANALOG 6'h39
`define RRA_IDX_BURST_ADDR 6'h3c
`define RRA_IDX_BURST_DATA 6'h3d
`define RRA_IDX_BURST_CTRL 6'h3e
// implemented bit masks
`define RRA_MSK_XTAL_CTRL 8'he7
`define RRA_MSK_GPIO_OUT 8'hf0
`define RRA_MSK_XACT_CFG 8'hbf
`define RRA_MSK_TH32 8'h0f
`define RRA_MSK_TH64 8'h1f
`define RRA_MSK_TRIM_HI 8'h0f
`define RRA_MSK_OP_OVR 8'h39
`define RRA_MSK_RX_OVR 8'hfe
`define RRA_MSK_XTAL_CFG 8'h08
`define RRA_MSK_CLK_BIT 8'h02
`define RRA_MSK_RX_ABORT 8'h20
`define RRA_MSK_ANALOG 8'h03
`define RRA_MSK_FULL 8'hff
// reset values
`define RRA_RST_XTAL_CTRL 8'h04
`define RRA_RST_XACT_CFG 8'h80
`define RRA_RST_FRAMING_CFG 8'ha5
`define RRA_RST_TH32 8'h04
`define RRA_RST_TH64 8'h0a
`define RRA_RST_EOP_CTRL 8'ha4
`define RRA_RST_CAL_TIME 8'h03
`define RRA_RST_ZERO 8'h00
`define RRA_RST_START_CODE 64'h17ff_9e21_3690_c782
`define RRA_RST_SPREAD_CODE 128'h02f9_9397_02fa_5ce3_012b_f1db_0132_be6f
`define RRA_RST_LEAD_IN 24'h33_3302
// file lengths minus one, in bytes
`define RRA_LAST_START_CODE 3'h7
`define RRA_LAST_SPREAD_CODE 4'hf
`define RRA_LAST_LEAD_IN 2'h2
`endif

// >>> verif/rra_reg_bank_monitor.sv
`timescale 1ns/1ns
module rra_reg_bank_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] signal_strength_indicator_value,
  input wire rx_pop,
  input wire tx_push,
  input wire [7:0] tx_byte,
  input wire [511:0] reg_image
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire done = pready && psel && penable;
  wire [5:0] idx = paddr[7:2];
  property p_answer; setup |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("ready not one cycle");
  property p_unmap; setup && idx < 6'h0c |=> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wo; setup && !pwrite && idx == 6'h1d |=> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("write-only read not zero");
  property p_signal_strength_indicator;
    setup && !pwrite && idx == 6'h13 |=> prdata[7:0] == ($past(signal_strength_indicator_value) & 8'hbf);
  endproperty
  a_signal_strength_indicator: assert property (p_signal_strength_indicator) else $error("strength read wrong");
  property p_push; done && pwrite && idx == 6'h20 |=> tx_push && tx_byte == $past(pwdata[7:0]);
  endproperty
  a_push: assert property (p_push) else $error("buffer push wrong");
  property p_pop; done && !pwrite && idx == 6'h21 |=> rx_pop; endproperty
  a_pop: assert property (p_pop) else $error("buffer pop missing");
  property p_one;
    done && pwrite && idx == 6'h15 |=>
      reg_image[175:168] == $past(pwdata[7:0]) && $stable(reg_image[183:176]);
  endproperty
  a_one: assert property (p_one) else $error("single write wrong");
  c_write: cover property (done && pwrite);
  c_pop: cover property (rx_pop);
  c_err: cover property (pready && pslverr);
endmodule // rra_reg_bank_monitor
bind rra_reg_bank rra_reg_bank_monitor rra_reg_bank_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .signal_strength_indicator_value(signal_strength_indicator_value), .rx_pop(rx_pop), .tx_push(tx_push), .tx_byte(tx_byte),
  .reg_image(reg_image));

// >>> verif/rra_status_src.sv
`timescale 1ns/1ns
module rra_status_src (
  input wire pclk,
  input wire presetn,
  input wire rx_pop,
  output reg [7:0] rx_byte,
  output wire [7:0] signal_strength_indicator_value,
  output wire [15:0] tx_crc,
  output wire [15:0] rx_crc,
  output wire [3:0] pin_in
);
  assign signal_strength_indicator_value = 8'hff;
  assign tx_crc = 16'h1234;
  assign rx_crc = 16'hbeef;
  assign pin_in = 4'ha;
  // next receive byte after each pop
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      rx_byte <= 8'h40;
    else if (rx_pop)
      rx_byte <= rx_byte + 8'h01;
endmodule // rra_status_src

// >>> verif/test_radio_register_access.sv
`timescale 1ns/1ns
module test_radio_register_access;
  reg pclk = 0;
  reg presetn = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, rx_pop;
  wire [7:0] rx_byte, signal_strength_indicator_value;
  wire [15:0] tx_crc, rx_crc;
  wire [3:0] pin_in;
  wire [63:0] start_code;
  wire [127:0] spread_code;
  wire [23:0] lead_in;
  wire [7:0] tx_byte;
  integer num_errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  always #5 pclk = ~pclk;
  rra_reg_bank rra_reg_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .signal_strength_indicator_value(signal_strength_indicator_value),
    .tx_crc(tx_crc), .rx_crc(rx_crc), .rx_byte(rx_byte), .rx_pop(rx_pop), .tx_push(),
    .tx_byte(tx_byte), .reg_image(), .start_code(start_code), .spread_code(spread_code),
    .lead_in(lead_in));
  rra_status_src rra_status_src_inst (.pclk(pclk), .presetn(presetn), .rx_pop(rx_pop),
    .rx_byte(rx_byte), .signal_strength_indicator_value(signal_strength_indicator_value), .tx_crc(tx_crc), .rx_crc(rx_crc),
    .pin_in(pin_in));
  task end_of_test;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] name, input [7:0] item, input [63:0] e, input [63:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s %h exp %h got %h", name, item, e, g);
      end
    end
  endtask
  task apb(input w, input [5:0] idx, input [7:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task rchk(input [5:0] idx, input [7:0] e);
    begin
      apb(0, idx, 8'h00);
      chk("read", idx, {24'h0, e}, rd);
    end
  endtask
  task rfile(input [5:0] idx, input integer n, input [127:0] v);
    for (i = 0; i < n; i = i + 1)
      rchk(idx, v[8*i+:8]);
  endtask
  task t_reset;
    begin
      rchk(6'h0c, 8'h04);
      rchk(6'h0f, 8'h80);
      rchk(6'h10, 8'ha5);
      rchk(6'h11, 8'h04);
      rchk(6'h12, 8'h0a);
      rchk(6'h14, 8'ha4);
      rchk(6'h0d, 8'h00);
      chk("scode", 0, 64'h17ff_9e21_3690_c782, start_code);
      chk("sprd_lo", 0, 64'h012b_f1db_0132_be6f, spread_code[63:0]);
      chk("sprd_hi", 0, 64'h02f9_9397_02fa_5ce3, spread_code[127:64]);
      chk("lead_in", 0, 24'h33_3302, lead_in);
      rfile(6'h22, 8, 64'h17ff_9e21_3690_c782);
      rfile(6'h23, 16, 128'h02f9_9397_02fa_5ce3_012b_f1db_0132_be6f);
      rfile(6'h24, 3, 24'h33_3302);
      $display("t_reset done");
    end
  endtask
  task t_single;
    begin
      apb(1, 6'h15, 8'h5a);
      rchk(6'h16, 8'h00);
      rchk(6'h15, 8'h5a);
      apb(1, 6'h17, 8'h00);
      rchk(6'h17, 8'h34);
      rchk(6'h1a, 8'hbe);
      apb(1, 6'h11, 8'hff);
      rchk(6'h11, 8'h0f);
      rchk(6'h1d, 8'h00);
      rchk(6'h13, 8'hbf);
      rchk(6'h0e, 8'h0a);
      apb(1, 6'h20, 8'h6c);
      chk("txbyte", 0, 8'h6c, tx_byte);
      apb(1, 6'h24, 8'h5c);
      chk("lead_in", 0, 24'h33_335c, lead_in);
      apb(0, 6'h00, 8'h00);
      chk("slverr", 0, 1, err);
      $display("t_single done");
    end
  endtask
  task t_burst;
    begin
      apb(1, 6'h3e, 8'h01);
      apb(1, 6'h3c, 8'h1b);
      apb(1, 6'h3d, 8'h11);
      apb(1, 6'h3d, 8'hff);
      rchk(6'h3c, 8'h1d);
      rchk(6'h1b, 8'h11);
      rchk(6'h1c, 8'h0f);
      apb(1, 6'h3e, 8'h00);
      apb(1, 6'h3c, 8'h21);
      for (i = 0; i < 3; i = i + 1)
        rchk(6'h3d, 8'h40 + i);
      rchk(6'h3c, 8'h21);
      rchk(6'h21, 8'h43);
      $display("t_burst done");
    end
  endtask
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  // radio kept idle; hint fields left at defaults, lowest preamble byte rewritten to 5c
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_single;
    t_burst;
    end_of_test;
  end
endmodule // test_radio_register_access
